/* rtl/tsmb_bridge.v */
// Two-wire slave bridge giving indirect access to management registers
//
// Operation
// - Answer only fixed slave address 0x7E
// - Write frames carry one offset byte after address
// - Offsets 125-127 hold device, address bytes
// - Offset 124 status; lower offsets read-only zero
// - Offsets 128/129 are high/low data bytes
// - Each further pair maps next register address
// - Window reads return mapped register contents
// - Undefined registers read zero, writes dropped
// - Controller ranges 1.Fxxx, 3.Dxxx are blocked
// - High byte read latches paired low byte
// - High byte buffered, low byte commits word
// - Management bus wins; loss sets status bit0
// - Configuration collision sets status bit1
// - Status bits sticky read-only; 7-2 reserved
`timescale 1ns/10ps
`include "tsmb_defs.vh"

module tsmb_bridge (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst_b,
    // Two-wire pins
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe,
    // Management register access port
    output reg         reg_req,
    output reg         reg_we,
    output reg  [7:0]  reg_dev,
    output reg  [15:0] reg_addr,
    output reg  [15:0] reg_wdata,
    input  wire        reg_ack,
    input  wire        reg_valid,
    input  wire [15:0] reg_rdata,
    // Arbitration inputs
    input  wire        mgmt_busy,
    input  wire        cfg_wr,
    // Status view
    output reg  [1:0]  cmd_status
);

    // Serial engine state
    reg        scl_m;
    reg        scl_s;
    reg        scl_d;
    reg        sda_m;
    reg        sda_s;
    reg        sda_d;
    reg [2:0]  st;
    reg [2:0]  ack_next;
    reg [3:0]  cnt;
    reg [7:0]  sh;
    reg [7:0]  tx_sh;
    reg [7:0]  offs;
    // Lower block registers and byte-pair holders
    reg [7:0]  dev_sel;
    reg [7:0]  addr_hi;
    reg [7:0]  addr_lo;
    reg [7:0]  wr_hold;
    reg [7:0]  rd_lo;
    reg [15:0] rd_word;
    // Requests from serial engine to access engine
    reg        fetch_go;
    reg        wr_go;
    reg [7:0]  go_ofs;

    wire scl_rise;
    wire scl_fall;
    wire bus_start;
    wire bus_stop;
    wire [7:0] next_offs;
    wire [15:0] go_addr;
    wire [7:0] tx_byte;

    // Serial engine states, binary coded
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_OFFS = 3'h2;
    localparam [2:0] ST_WDAT = 3'h3;
    localparam [2:0] ST_RDAT = 3'h4;
    localparam [2:0] ST_ACK  = 3'h5;
    localparam [2:0] ST_RACK = 3'h6;

    // Window register address: base plus pair index
    function [15:0] win_addr;
        input [15:0] base;
        input [7:0]  ofs;
        begin
            win_addr = base + {10'h000, ofs[6:1]};
        end
    endfunction

    // Microcontroller ranges are never reached
    function is_blocked;
        input [7:0]  dev;
        input [15:0] a;
        begin
            is_blocked = ((dev == `TSMB_BLK_DEV_A) && (a[15:12] == `TSMB_BLK_NIB_A))
                || ((dev == `TSMB_BLK_DEV_B) && (a[15:12] == `TSMB_BLK_NIB_B));
        end
    endfunction

    // A window fetch is needed only for an even (high) byte
    function needs_fetch;
        input [7:0] ofs;
        begin
            needs_fetch = ofs[`TSMB_WIN_BIT] & ~ofs[0];
        end
    endfunction

    // Two-stage synchronisers, then a delayed copy for edges
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
    assign next_offs = offs + 8'h01;
    assign go_addr   = win_addr({addr_hi, addr_lo}, go_ofs);

    // Byte presented on a read: the low byte comes from the latch
    assign tx_byte = offs[`TSMB_WIN_BIT] ? (offs[0] ? rd_lo : rd_word[15:8])
        : (offs == `TSMB_OFS_STATUS)  ? {6'h00, cmd_status}
        : (offs == `TSMB_OFS_DEV)     ? dev_sel
        : (offs == `TSMB_OFS_ADDR_HI) ? addr_hi
        : (offs == `TSMB_OFS_ADDR_LO) ? addr_lo
        : `TSMB_RST_BYTE;

    // Serial engine: framing, shifting, acknowledge and offset handling
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st       <= ST_IDLE;
            ack_next <= ST_IDLE;
            cnt      <= 4'h0;
            sh       <= `TSMB_RST_BYTE;
            tx_sh    <= `TSMB_RST_BYTE;
            offs     <= `TSMB_RST_BYTE;
            dev_sel  <= `TSMB_RST_BYTE;
            addr_hi  <= `TSMB_RST_BYTE;
            addr_lo  <= `TSMB_RST_BYTE;
            wr_hold  <= `TSMB_RST_BYTE;
            rd_lo    <= `TSMB_RST_BYTE;
            sda_out  <= 1'b0;
            sda_oe   <= 1'b0;
            fetch_go <= 1'b0;
            wr_go    <= 1'b0;
            go_ofs   <= `TSMB_RST_BYTE;
        end else begin
            fetch_go <= 1'b0;
            wr_go    <= 1'b0;
            if (bus_start) begin
                // Repeated start also lands here; offset is kept
                st     <= ST_ADDR;
                cnt    <= 4'h0;
                sda_oe <= 1'b0;
            end else if (bus_stop) begin
                st     <= ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (st)
                    ST_ADDR, ST_OFFS, ST_WDAT: begin
                        if (scl_rise) begin
                            sh  <= {sh[6:0], sda_s};
                            cnt <= cnt + 4'h1;
                        end else if (scl_fall && (cnt == `TSMB_BITS_BYTE)) begin
                            cnt <= 4'h0;
                            if (st == ST_ADDR) begin
                                if (sh[7:1] == `TSMB_SLAVE_ADDR) begin
                                    sda_oe <= 1'b1;
                                    st     <= ST_ACK;
                                    if (sh[0]) begin
                                        // Read from the current offset
                                        ack_next <= ST_RDAT;
                                        fetch_go <= needs_fetch(offs);
                                        go_ofs   <= offs;
                                    end else begin
                                        ack_next <= ST_OFFS;
                                    end
                                end else begin
                                    // Another slave's frame: stay quiet
                                    st <= ST_IDLE;
                                end
                            end else if (st == ST_OFFS) begin
                                offs     <= sh;
                                sda_oe   <= 1'b1;
                                st       <= ST_ACK;
                                ack_next <= ST_WDAT;
                            end else begin
                                // Data byte written at the current offset
                                if (offs[`TSMB_WIN_BIT]) begin
                                    if (!offs[0]) begin
                                        wr_hold <= sh;
                                    end else begin
                                        wr_go  <= 1'b1;
                                        go_ofs <= offs;
                                    end
                                end else if (offs == `TSMB_OFS_DEV) begin
                                    dev_sel <= sh;
                                end else if (offs == `TSMB_OFS_ADDR_HI) begin
                                    addr_hi <= sh;
                                end else if (offs == `TSMB_OFS_ADDR_LO) begin
                                    addr_lo <= sh;
                                end
                                // Status and reserved bytes ignore writes
                                offs     <= next_offs;
                                sda_oe   <= 1'b1;
                                st       <= ST_ACK;
                                ack_next <= ST_WDAT;
                            end
                        end
                    end
                    ST_ACK: begin
                        // Our acknowledge bit ends on this falling edge
                        if (scl_fall) begin
                            st  <= ack_next;
                            cnt <= 4'h0;
                            if (ack_next == ST_RDAT) begin
                                tx_sh  <= {tx_byte[6:0], 1'b0};
                                sda_oe <= ~tx_byte[7];
                                if (needs_fetch(offs)) begin
                                    rd_lo <= rd_word[7:0];
                                end
                            end else begin
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    ST_RDAT: begin
                        if (scl_fall) begin
                            if (cnt == `TSMB_LAST_BIT) begin
                                // Release for the master's acknowledge
                                sda_oe   <= 1'b0;
                                st       <= ST_RACK;
                                offs     <= next_offs;
                                fetch_go <= needs_fetch(next_offs);
                                go_ofs   <= next_offs;
                            end else begin
                                sda_oe <= ~tx_sh[7];
                                tx_sh  <= {tx_sh[6:0], 1'b0};
                                cnt    <= cnt + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise && sda_s) begin
                            // Not acknowledged: wait for stop or start
                            st <= ST_IDLE;
                        end else if (scl_fall) begin
                            st     <= ST_RDAT;
                            cnt    <= 4'h0;
                            tx_sh  <= {tx_byte[6:0], 1'b0};
                            sda_oe <= ~tx_byte[7];
                            if (needs_fetch(offs)) begin
                                rd_lo <= rd_word[7:0];
                            end
                        end
                    end
                    default: begin
                        st     <= ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Access engine: one register transfer at a time
    // The fetch is issued a whole bit period before the byte is
    // shifted out, so the register side must answer well inside it.
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_req   <= 1'b0;
            reg_we    <= 1'b0;
            reg_dev   <= `TSMB_RST_BYTE;
            reg_addr  <= `TSMB_RST_WORD;
            reg_wdata <= `TSMB_RST_WORD;
            rd_word   <= `TSMB_RST_WORD;
        end else if (reg_req) begin
            if (reg_ack) begin
                reg_req <= 1'b0;
                if (!reg_we) begin
                    rd_word <= reg_valid ? reg_rdata : `TSMB_RST_WORD;
                end
            end
        end else if (fetch_go || wr_go) begin
            if (is_blocked(dev_sel, go_addr)) begin
                // Blocked: reads give zero, writes vanish
                if (fetch_go) begin
                    rd_word <= `TSMB_RST_WORD;
                end
            end else if (mgmt_busy) begin
                // Management bus has priority; this access is lost
                if (fetch_go) begin
                    rd_word <= `TSMB_RST_WORD;
                end
            end else begin
                reg_req   <= 1'b1;
                reg_we    <= wr_go;
                reg_dev   <= dev_sel;
                reg_addr  <= go_addr;
                reg_wdata <= {wr_hold, sh};
            end
        end
    end

    // Sticky failure flags; only reset clears them
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmd_status <= `TSMB_RST_STAT;
        end else begin
            if (!reg_req && (fetch_go || wr_go) && mgmt_busy
                && !is_blocked(dev_sel, go_addr)) begin
                cmd_status[`TSMB_STAT_BRIDGE] <= 1'b1;
            end
            if (mgmt_busy && cfg_wr) begin
                cmd_status[`TSMB_STAT_CONFIG] <= 1'b1;
            end
        end
    end

endmodule

/* rtl/tsmb_defs.vh */
// Constants for the two-wire slave bridge onto the management register space
`ifndef TSMB_DEFS_VH
`define TSMB_DEFS_VH

// Fixed slave address, 7-bit form of the 0x7E address byte
`define TSMB_SLAVE_ADDR    7'h3f

// Byte offsets in the lower block
`define TSMB_OFS_STATUS    8'h7c
`define TSMB_OFS_DEV       8'h7d
`define TSMB_OFS_ADDR_HI   8'h7e
`define TSMB_OFS_ADDR_LO   8'h7f

// Offset bit that selects the upper window block
`define TSMB_WIN_BIT       7

// Reset values
`define TSMB_RST_BYTE      8'h00
`define TSMB_RST_WORD      16'h0000
`define TSMB_RST_STAT      2'h0

// Command-status bit positions
`define TSMB_STAT_BRIDGE   0
`define TSMB_STAT_CONFIG   1

// Device and address nibble of the blocked controller ranges
`define TSMB_BLK_DEV_A     8'h01
`define TSMB_BLK_NIB_A     4'hf
`define TSMB_BLK_DEV_B     8'h03
`define TSMB_BLK_NIB_B     4'hd

// Serial sequencing counts
`define TSMB_BITS_BYTE     4'h8
`define TSMB_LAST_BIT      4'h7

`endif

/* tb/tsmb_bridge_asserts.sv */
// Concurrent checks on the bridge register port and status flags
`timescale 1ns/10ps
module tsmb_bridge_asserts (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // Register port
    input wire logic        reg_req,
    input wire logic        reg_we,
    input wire logic [7:0]  reg_dev,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_ack,
    // Arbitration and status
    input wire logic        mgmt_busy,
    input wire logic        cfg_wr,
    input wire logic [1:0]  cmd_status
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // An access is answered inside one bus bit, then withdrawn at once
    sequence answered;
        ##[0:60] reg_ack;
    endsequence
    sequence withdrawn;
        !reg_req;
    endsequence
    held_request_a: assert property (reg_req && !reg_ack |=> reg_req
        && $stable({reg_we, reg_dev, reg_addr, reg_wdata}))
        else $error("request changed before its answer");
    request_release_a: assert property ($rose(reg_req) |-> answered ##1 withdrawn)
        else $error("request not withdrawn after answer");
    mgmt_first_a: assert property ($rose(reg_req) |-> !$past(mgmt_busy))
        else $error("request issued while management bus busy");
    loss_flag_a: assert property ($rose(cmd_status[0]) |-> $past(mgmt_busy))
        else $error("loss flag set without management traffic");
    cfg_collide_a: assert property (mgmt_busy && cfg_wr |=> cmd_status[1])
        else $error("collision flag missing");
    cfg_cause_a: assert property ($rose(cmd_status[1]) |-> $past(mgmt_busy && cfg_wr))
        else $error("collision flag set without collision");
    flags_sticky_a: assert property (!$fell(cmd_status[0]) && !$fell(cmd_status[1]))
        else $error("status flag cleared");
    blocked_range_a: assert property (reg_req |-> !(reg_dev == 8'h01 && reg_addr[15:12] == 4'hf)
        && !(reg_dev == 8'h03 && reg_addr[15:12] == 4'hd))
        else $error("controller range reached");
endmodule
bind tsmb_bridge tsmb_bridge_asserts u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_req(reg_req), .reg_we(reg_we), .reg_dev(reg_dev), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_ack(reg_ack), .mgmt_busy(mgmt_busy),
    .cfg_wr(cfg_wr), .cmd_status(cmd_status));

/* tb/tsmb_i2c_master.sv */
// Two-wire bus master model standing in for the external processor
`timescale 1ns/10ps
module tsmb_i2c_master #(parameter int HALF = 30) (
    // Clock
    input  wire logic clk_sys,
    // Bus lines
    input  wire logic sda,
    output logic      scl,
    output logic      sda_oe
);
    initial begin
        scl    = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic half;
        repeat (HALF) @(posedge clk_sys);
    endtask
    // Data moves a few cycles after the clock falls, so no false start is seen
    task automatic put(input logic v);
        repeat (4) @(posedge clk_sys);
        sda_oe <= v;
    endtask
    task automatic start;
        put(1'b0);
        half;
        scl <= 1'b1;
        half;
        put(1'b1);
        half;
        scl <= 1'b0;
    endtask
    task automatic stop;
        put(1'b1);
        half;
        scl <= 1'b1;
        half;
        put(1'b0);
        half;
    endtask
    task automatic clk_bit(output logic v);
        half;
        scl <= 1'b1;
        half;
        v = sda;
        scl <= 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            put(!b[i]);
            clk_bit(ack);
        end
        put(1'b0);
        clk_bit(ack);
        ack = !ack;
    endtask
    // Last byte of a read gets no acknowledge
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic v;
        put(1'b0);
        for (int i = 0; i < 8; i++) begin
            clk_bit(v);
            d = {d[6:0], v};
        end
        put(!last);
        clk_bit(v);
    endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the two-wire register bridge
`timescale 1ns/10ps
module tb_top;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        scl, m_oe, sda_out, sda_oe, reg_req, reg_we, a;
    logic [7:0]  reg_dev, b, o;
    logic [15:0] reg_addr, reg_wdata, w;
    logic        reg_ack = 1'b0;
    logic        reg_valid = 1'b0;
    logic [15:0] reg_rdata = 16'h0000;
    logic        mgmt_busy = 1'b0;
    logic        cfg_wr = 1'b0;
    logic [1:0]  cmd_status;
    logic [5:0]  k;
    logic [15:0] rmem [64];
    logic [15:0] shadow [64];
    logic [7:0]  wq[$], rq[$], eq[$];
    int          seed = 32'h1e9c_39ce;
    int          wcnt = 0;
    int          n_errors = 0;
    int          n_tests = 0;
    // Open-drain data line with pull-up
    wire sda = !m_oe && (sda_oe ? sda_out : 1'b1);
    always #5 clk_sys = !clk_sys;
    tsmb_bridge dut (.clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .reg_req(reg_req), .reg_we(reg_we),
        .reg_dev(reg_dev), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
        .reg_valid(reg_valid), .reg_rdata(reg_rdata), .mgmt_busy(mgmt_busy),
        .cfg_wr(cfg_wr), .cmd_status(cmd_status));
    tsmb_i2c_master #(.HALF(20)) m (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_oe(m_oe));
    // Register side: random delay, only even words of device 1 block C000 defined
    wire reg_known = reg_dev == 8'h01 && reg_addr[15:6] == 10'h300 && !reg_addr[0];
    always @(posedge clk_sys) begin
        reg_ack   <= 1'b0;
        reg_valid <= seed[3];
        reg_rdata <= 16'($random(seed));
        if (reg_req && !reg_ack) begin
            if (wcnt == 0) begin
                reg_ack   <= 1'b1;
                reg_valid <= reg_known;
                reg_rdata <= reg_known ? rmem[reg_addr[5:0]] : 16'hffff;
                if (reg_we && reg_known)
                    rmem[reg_addr[5:0]] <= reg_wdata;
                wcnt <= $random(seed) & 7;
            end else
                wcnt <= wcnt - 1;
        end
    end
    // Window byte expected from the written words; odd registers read zero
    function automatic logic [7:0] win_exp(input logic [7:0] ofs);
        w = shadow[ofs[6:1]];
        return ofs[1] ? 8'h00 : (ofs[0] ? w[7:0] : w[15:8]);
    endfunction
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic match(input string what);
        foreach (eq[i])
            chk(what, eq[i], rq[i]);
        eq.delete();
        rq.delete();
    endtask
    // Write frame: slave address, one offset byte, then queued bytes
    task automatic send(input logic [7:0] ofs);
        m.start;
        m.wbyte(8'h7e, a);
        chk("slave ack", 8'h01, {7'h00, a});
        m.wbyte(ofs, a);
        foreach (wq[i])
            m.wbyte(wq[i], a);
        m.stop;
        wq.delete();
    endtask
    task automatic fetch(input logic [7:0] ofs, input int n);
        send(ofs);
        m.start;
        m.wbyte(8'h7f, a);
        for (int i = 0; i < n; i++) begin
            m.rbyte(i == n - 1, b);
            rq.push_back(b);
        end
        m.stop;
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        // Frames need about 60k cycles; a hang stops short of 100k
        #900_000;
        n_errors++;
        complete_run;
    end
    initial begin
        foreach (rmem[i]) begin
            rmem[i] = 16'h0000;
            shadow[i] = 16'h0000;
        end
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        fetch(8'h7b, 5);
        eq = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        match("lower block after reset");
        wq = '{8'h01, 8'hc0, 8'h00};
        send(8'h7d);
        wq = '{8'h5a};
        send(8'h10);
        fetch(8'h10, 1);
        eq = '{8'h00};
        match("reserved byte");
        fetch(8'h7d, 3);
        eq = '{8'h01, 8'hc0, 8'h00};
        match("target bytes");
        // Random words, with the first and last window pairs forced
        for (int n = 0; n < 5; n++) begin
            k = (n == 0) ? 6'h00 : (n == 1) ? 6'h3f : 6'($random(seed));
            w = 16'($random(seed));
            cfg_wr <= k[0];
            o = {1'b1, k, 1'b0};
            wq = '{w[15:8], w[7:0]};
            send(o);
            if (!k[0])
                shadow[k] = w;
            fetch(o, 2);
            eq = '{win_exp(o), win_exp(o + 8'h01)};
            match("window word");
        end
        cfg_wr <= 1'b0;
        fetch(8'h80, 4);
        eq = '{win_exp(8'h80), win_exp(8'h81), win_exp(8'h82), win_exp(8'h83)};
        match("window burst");
        // Low byte must come from the copy taken with the high byte
        eq = '{win_exp(8'h80), win_exp(8'h81)};
        fetch(8'h80, 1);
        // Word changes after the high byte; the low byte must not follow it
        rmem[0] = ~shadow[0];
        shadow[0] = ~shadow[0];
        fetch(8'h81, 1);
        match("latched low byte");
        for (int j = 0; j < 2; j++) begin
            wq = '{j ? 8'h03 : 8'h01, j ? 8'hd0 : 8'hf0, 8'h00};
            send(8'h7d);
            fetch(8'h80, 2);
            eq = '{8'h00, 8'h00};
            match("controller range");
        end
        wq = '{8'h01, 8'hc0, 8'h00};
        send(8'h7d);
        // Lost write while the management bus is busy, then a collision
        mgmt_busy <= 1'b1;
        wq = '{8'h12, 8'h34};
        send(8'h80);
        cfg_wr <= 1'b1;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
        mgmt_busy <= 1'b0;
        fetch(8'h7c, 4);
        eq = '{8'h03, 8'h01, 8'hc0, 8'h00};
        match("status after loss");
        fetch(8'h80, 2);
        eq = '{win_exp(8'h80), win_exp(8'h81)};
        match("dropped write");
        m.start;
        m.wbyte(8'h7c, a);
        chk("foreign address ack", 8'h00, {7'h00, a});
        m.stop;
        complete_run;
    end
endmodule
